// [rtl/charge_time_pkg.sv]
// package: register map, field layout and reset values of the charge time unit
package charge_time_pkg;
    localparam logic [3:0] OFF_CTRL_HIGH  = 4'h0;
    localparam logic [3:0] OFF_CTRL_LOW   = 4'h4;
    localparam logic [3:0] OFF_CURRENT    = 4'h8;
    localparam logic [3:0] OFF_FLAGS      = 4'hc;
    localparam int HI_UNIT_ENABLE   = 7;
    localparam int HI_STOP_IDLE     = 5;
    localparam int HI_TIME_GEN      = 4;
    localparam int HI_EDGE_UNBLOCK  = 3;
    localparam int HI_SEQ_ENABLE    = 2;
    localparam int HI_DISCHARGE     = 1;
    localparam int HI_TRIG_ENABLE   = 0;
    localparam int LO_POL2          = 7;
    localparam int LO_SRC2_LSB      = 5;
    localparam int LO_POL1          = 4;
    localparam int LO_SRC1_LSB      = 2;
    localparam int LO_STAT2         = 1;
    localparam int LO_STAT1         = 0;
    localparam int CUR_TRIM_LSB     = 2;
    localparam int CUR_RANGE_LSB    = 0;
    localparam int FLG_IRQ          = 3;
    localparam logic [7:0] HI_WMASK = 8'hbf;
    localparam logic [7:0] RST_CTRL_HIGH = 8'h00;
    localparam logic [7:0] RST_CTRL_LOW  = 8'h00;
    localparam logic [7:0] RST_CURRENT   = 8'h00;
    localparam logic [1:0] SRC_PIN_ONE   = 2'h3;
    localparam logic [1:0] SRC_PIN_TWO   = 2'h2;
    localparam logic [1:0] SRC_CAPT_ONE  = 2'h1;
    localparam logic [1:0] SRC_CAPT_TWO  = 2'h0;
    localparam logic [1:0] RNG_X100      = 2'h3;
    localparam logic [1:0] RNG_X10       = 2'h2;
    localparam logic [1:0] RNG_BASE      = 2'h1;
    localparam logic [1:0] RNG_OFF       = 2'h0;
    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;
endpackage : charge_time_pkg

// [rtl/charge_time_unit.sv]
// charge time unit: edge channels, status flags, current gate, AXI4-Lite registers
// Function
// - two-bit range selector gives three current ranges over two decades.
// - range 11 is x100, 10 is x10, 01 base, 00 disabled.
// - six-bit signed trim at bits 7:2, zero means no change.
// - two channels, source select at bits 3:2 and 6:5.
// - source 11 pin one, 10 pin two, 01 capture one, 00 capture two.
// - channels respond to present level, not transitions.
// - polarity bits 7 and 4 pick active level, negative by default.
// - with sequencing on, channel two accepted only after channel one.
// - channel status bits 1:0 set on active response.
// - reconfiguration matching the present level sets status at once.
// - current on only while exactly one status bit is set.
// - software may write status bits directly to gate the current.
// - interrupt flag bit 3 sets when current goes on to off; enable gates irq_q only.
// - time generation bit selects delay mode; measurement is default.
// - trigger bit starts a conversion on the second edge event.
// - discharge bit grounds the current output while set.
// - bit 7 enables the unit; bit 3 unblocks edge inputs.
// - pulse generation uses comparator two and its reference.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
module charge_time_unit
    import charge_time_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        edge_pin_one,
    input  wire logic        edge_pin_two,
    input  wire logic        capture_one_trig,
    input  wire logic        capture_two_trig,
    input  wire logic        irq_enable,
    input  wire logic        comparator_two_out,
    output logic             current_on_q,
    output logic             discharge_ground_q,
    output logic [2:0]       current_range_q,
    output logic [5:0]       current_trim_q,
    output logic             converter_start_q,
    output logic             delay_mode_q,
    output logic             comparator_two_enable_q,
    output logic             irq_q,
    output logic             unit_active_q
);
    function automatic logic pick_source(input logic [1:0] sel, input logic [3:0] src);
        logic v;
        v = 1'b0;
        unique case (sel)
            SRC_PIN_ONE:  v = src[3];
            SRC_PIN_TWO:  v = src[2];
            SRC_CAPT_ONE: v = src[1];
            SRC_CAPT_TWO: v = src[0];
        endcase
        return v;
    endfunction

    logic [7:0] ctrl_high_q;
    logic [7:0] ctrl_low_q;
    logic [7:0] current_q;
    logic       irq_flag_q;
    logic       stat1_q;
    logic       stat2_q;
    logic       aw_held_q;
    logic [3:0] aw_addr_q;
    logic       w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [3:0] src_sync;
    logic       pulse_out_q;

    edge_sync u_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({edge_pin_one, edge_pin_two, capture_one_trig, capture_two_trig}),
        .sync_out (src_sync)
    );

    current_range_decode u_range (
        .clk            (clk),
        .arst_n         (arst_n),
        .range_sel      (current_q[CUR_RANGE_LSB +: 2]),
        .trim_sel       (current_q[CUR_TRIM_LSB +: 6]),
        .source_on      (ctrl_high_q[HI_UNIT_ENABLE]),
        .range_onehot_q (current_range_q),
        .trim_q         (current_trim_q)
    );

    // write channel capture, either order
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
    wire wr_hit  = (aw_addr_q == OFF_CTRL_HIGH) || (aw_addr_q == OFF_CTRL_LOW) ||
                   (aw_addr_q == OFF_CURRENT) || (aw_addr_q == OFF_FLAGS);
    wire wr_high = wr_go && aw_addr_q == OFF_CTRL_HIGH && w_strb_q[0];
    wire wr_low  = wr_go && aw_addr_q == OFF_CTRL_LOW && w_strb_q[0];
    wire wr_cur  = wr_go && aw_addr_q == OFF_CURRENT && w_strb_q[0];
    wire wr_flag = wr_go && aw_addr_q == OFF_FLAGS && w_strb_q[0];
    wire [7:0] wbyte = w_data_q[7:0];

    // channel evaluation
    wire [7:0] low_eff = wr_low ? wbyte : ctrl_low_q;
    wire lvl1 = pick_source(low_eff[LO_SRC1_LSB +: 2], src_sync);
    wire lvl2 = pick_source(low_eff[LO_SRC2_LSB +: 2], src_sync);
    wire act1 = lvl1 == low_eff[LO_POL1];
    wire act2 = lvl2 == low_eff[LO_POL2];
    wire armed = ctrl_high_q[HI_UNIT_ENABLE] && ctrl_high_q[HI_EDGE_UNBLOCK];
    wire stat1_base = wr_low ? wbyte[LO_STAT1] : stat1_q;
    wire stat2_base = wr_low ? wbyte[LO_STAT2] : stat2_q;
    wire hit1 = armed && act1;
    wire seq_ok = !ctrl_high_q[HI_SEQ_ENABLE] || stat1_q;
    wire hit2 = armed && act2 && seq_ok;
    wire stat1_d = stat1_base || hit1;
    wire stat2_d = stat2_base || hit2;
    wire gate_d = (stat1_d ^ stat2_d) && ctrl_high_q[HI_UNIT_ENABLE];
    wire on_d = gate_d && !ctrl_high_q[HI_DISCHARGE];
    wire gate_fall = current_on_q && !on_d;
    wire second_evt = hit2 && !stat2_q && stat1_d;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_high_q <= RST_CTRL_HIGH;
            ctrl_low_q  <= RST_CTRL_LOW;
            current_q   <= RST_CURRENT;
        end else begin
            if (wr_high) ctrl_high_q <= wbyte & HI_WMASK;
            if (wr_low) ctrl_low_q <= {wbyte[7:2], 2'b00};
            if (wr_cur) current_q <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat1_q <= 1'b0;
            stat2_q <= 1'b0;
        end else begin
            stat1_q <= stat1_d;
            stat2_q <= stat2_d;
        end
    end

    // sticky flag: a new falling gate wins over a software clear
    wire irq_flag_d = gate_fall || (irq_flag_q && !(wr_flag && !wbyte[FLG_IRQ]));
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_flag_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            irq_flag_q <= irq_flag_d;
            irq_q      <= irq_flag_d && irq_enable;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            current_on_q            <= 1'b0;
            discharge_ground_q      <= 1'b0;
            converter_start_q       <= 1'b0;
            delay_mode_q            <= 1'b0;
            comparator_two_enable_q <= 1'b0;
            unit_active_q           <= 1'b0;
            pulse_out_q             <= 1'b0;
        end else begin
            current_on_q            <= on_d;
            discharge_ground_q      <= ctrl_high_q[HI_DISCHARGE];
            converter_start_q       <= second_evt && ctrl_high_q[HI_TRIG_ENABLE];
            delay_mode_q            <= ctrl_high_q[HI_TIME_GEN];
            comparator_two_enable_q <= ctrl_high_q[HI_TIME_GEN] &&
                                       ctrl_high_q[HI_UNIT_ENABLE];
            unit_active_q           <= ctrl_high_q[HI_UNIT_ENABLE];
            pulse_out_q             <= comparator_two_out;
        end
    end

    // AXI4-Lite write side
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 4'h0;
            w_data_q      <= 32'h0000_0000;
            w_strb_q      <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_q && !aw_take;
            s_axi_wready  <= !w_held_q && !w_take;
            if (aw_take) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held_q     <= 1'b0;
                w_held_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side
    wire [3:0] ra = {s_axi_araddr[3:2], 2'b00};
    wire [7:0] low_rd = {ctrl_low_q[7:2], stat2_q, stat1_q};
    wire rd_hit = (ra == OFF_CTRL_HIGH) || (ra == OFF_CTRL_LOW) ||
                  (ra == OFF_CURRENT) || (ra == OFF_FLAGS);
    wire [7:0] rd_byte = (ra == OFF_CTRL_HIGH) ? ctrl_high_q :
                         (ra == OFF_CTRL_LOW)  ? low_rd :
                         (ra == OFF_CURRENT)   ? current_q :
                         (ra == OFF_FLAGS)     ? {4'h0, irq_flag_q, 3'h0} : 8'h00;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, rd_byte};
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    AST_EXCLUSIVE_GATE: assert property (@(posedge clk) disable iff (!arst_n)
        current_on_q |-> ($past(stat1_d) ^ $past(stat2_d)))
        else $error("current on without exactly one status bit");
    AST_DISCHARGE_OFF: assert property (@(posedge clk) disable iff (!arst_n)
        $past(ctrl_high_q[HI_DISCHARGE]) |-> !current_on_q)
        else $error("current on during discharge");
    AST_IRQ_ON_FALL: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(current_on_q) |-> irq_flag_q)
        else $error("flag not set on current turn off");
    AST_SEQ_ORDER: assert property (@(posedge clk) disable iff (!arst_n)
        (ctrl_high_q[HI_SEQ_ENABLE] && !stat1_q && !wr_low) |=> !($rose(stat2_q)))
        else $error("channel two accepted before channel one");
    AST_BLOCKED: assert property (@(posedge clk) disable iff (!arst_n)
        (!ctrl_high_q[HI_EDGE_UNBLOCK] && !wr_low) |=> $stable(stat1_q))
        else $error("status moved with edges blocked");
    AST_LEVEL_SET: assert property (@(posedge clk) disable iff (!arst_n)
        (armed && act1) |=> stat1_q)
        else $error("active level did not set status one");
    AST_TRIGGER: assert property (@(posedge clk) disable iff (!arst_n)
        converter_start_q |-> $past(ctrl_high_q[HI_TRIG_ENABLE]) && $rose(stat2_q))
        else $error("trigger without second edge");
    AST_SW_STATUS: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_low && wbyte[1:0] == 2'b01) |=> stat1_q)
        else $error("software status write lost");
endmodule // charge_time_unit

// [rtl/current_range_decode.sv]
// decoder of the current range and trim into source controls
`timescale 1ns/100ps
module current_range_decode
    import charge_time_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [1:0] range_sel,
    input  wire logic [5:0] trim_sel,
    input  wire logic       source_on,
    output logic      [2:0] range_onehot_q,
    output logic      [5:0] trim_q
);
    logic [2:0] range_onehot_d;
    always_comb begin
        unique case (range_sel)
            RNG_X100: range_onehot_d = 3'h4;
            RNG_X10:  range_onehot_d = 3'h2;
            RNG_BASE: range_onehot_d = 3'h1;
            RNG_OFF:  range_onehot_d = 3'h0;
        endcase
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            range_onehot_q <= 3'h0;
            trim_q         <= 6'h00;
        end else begin
            range_onehot_q <= source_on ? range_onehot_d : 3'h0;
            trim_q         <= trim_sel;
        end
    end
endmodule // current_range_decode

// [rtl/edge_sync.sv]
// two-stage synchroniser for the selectable edge sources
`timescale 1ns/100ps
module edge_sync
    import charge_time_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] async_in,
    output logic      [3:0] sync_out
);
    logic [3:0] meta_q;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q[g]   <= 1'b0;
                    sync_out[g] <= 1'b0;
                end else begin
                    meta_q[g]   <= async_in[g];
                    sync_out[g] <= meta_q[g];
                end
            end
        end
    endgenerate
endmodule // edge_sync

// [sim/charge_time_unit_test.sv]
// self-checking testbench of the charge time unit
`timescale 1ns/100ps
module charge_time_unit_test
    import charge_time_pkg::*;
;
    typedef struct packed {
        logic [7:0] cfg;
        logic [3:0] lvl;
        logic [1:0] stat;
        logic       on;
    } row_s;
    logic        clk           = 1'b0;
    logic        arst_n        = 1'b0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    logic        irq_enable    = 1'b0;
    logic [3:0]  s_axi_awaddr  = 4'h0;
    logic [3:0]  s_axi_araddr  = 4'h0;
    logic [3:0]  level_cmd     = 4'h0;
    logic [31:0] s_axi_wdata   = 32'h0;
    logic [1:0]  last_bresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        edge_pin_one, edge_pin_two, capture_one_trig, capture_two_trig;
    logic        current_on_q, discharge_ground_q, converter_start_q, delay_mode_q;
    logic        comparator_two_enable_q, irq_q, unit_active_q;
    logic [2:0]  current_range_q;
    logic [5:0]  current_trim_q;
    int          conv_count;
    int          cycles        = 0;
    int          err_count     = 0;
    int          comparisons   = 0;
    // channel config, levels {capt2,capt1,pin2,pin1}, expected status and gate
    row_s        rows [6]      = '{'{8'hdc, 4'h1, 2'h1, 1'b1}, '{8'hf8, 4'h2, 2'h1, 1'b1},
                                   '{8'h94, 4'h4, 2'h1, 1'b1}, '{8'hb0, 4'h8, 2'h1, 1'b1},
                                   '{8'hdc, 4'h3, 2'h3, 1'b0}, '{8'h0c, 4'h1, 2'h2, 1'b1}};

    charge_time_unit dut (
        .clk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .edge_pin_one, .edge_pin_two,
        .capture_one_trig, .capture_two_trig, .irq_enable, .comparator_two_out(1'b0),
        .current_on_q, .discharge_ground_q, .current_range_q, .current_trim_q,
        .converter_start_q, .delay_mode_q, .comparator_two_enable_q, .irq_q, .unit_active_q
    );
    edge_source_model partner (
        .clk, .arst_n, .level_cmd, .converter_start_q, .edge_pin_one, .edge_pin_two,
        .capture_one_trig, .capture_two_trig, .conv_count
    );

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count = err_count + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        last_bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [33:0] got);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        got = {s_axi_rresp, s_axi_rdata};
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string what);
        logic [33:0] got;
        rd(a, got);
        chk(got, {RESP_OKAY, 24'h0, e}, what);
    endtask
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    initial begin
        logic [33:0] got;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            wr(OFF_CTRL_HIGH, 8'h80);
            wr(OFF_CTRL_LOW, rows[i].cfg);
            level_cmd <= rows[i].lvl;
            wr(OFF_CTRL_HIGH, 8'h88);
            settle();
            rd_chk(OFF_CTRL_LOW, rows[i].cfg | 8'(rows[i].stat), "status");
            chk(34'(current_on_q), 34'(rows[i].on), "gate");
        end
        $display("test edge table done");
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        level_cmd <= 4'h0;
        chk(34'({current_on_q, unit_active_q, irq_q}), 34'h0, "outputs after reset");
        // low address bits are dropped: offset 2 lands on control high
        wr(4'h2, RST_CTRL_HIGH);
        chk(34'(last_bresp), 34'(RESP_OKAY), "aliased write");
        rd(4'h2, got);
        chk(got, {RESP_OKAY, 24'h0, RST_CTRL_HIGH}, "aliased read");
        rd_chk(OFF_CTRL_HIGH, RST_CTRL_HIGH, "reset high");
        rd_chk(OFF_CTRL_LOW, RST_CTRL_LOW, "reset low");
        rd_chk(OFF_CURRENT, RST_CURRENT, "reset current");
        rd_chk(OFF_FLAGS, 8'h00, "reset flags");
        wr(OFF_CTRL_HIGH, 8'hf2);
        rd_chk(OFF_CTRL_HIGH, 8'hf2 & HI_WMASK, "high readback");
        settle();
        chk(34'({discharge_ground_q, delay_mode_q, unit_active_q}), 34'h7, "high");
        chk(34'(comparator_two_enable_q), 34'h1, "comparator on");
        wr(OFF_CTRL_HIGH, 8'h80);
        settle();
        chk(34'({discharge_ground_q, delay_mode_q, unit_active_q}), 34'h1, "released");
        chk(34'(comparator_two_enable_q), 34'h0, "comparator off");
        $display("test reset and control done");
        for (int r = 0; r < 4; r++) begin
            wr(OFF_CURRENT, {6'h1f + 6'(r), 2'(r)});
            settle();
            rd_chk(OFF_CURRENT, {6'h1f + 6'(r), 2'(r)}, "current readback");
            got = 34'({(r == 0) ? 3'h0 : 3'(1 << (r - 1)), 6'h1f + 6'(r)});
            chk(34'({current_range_q, current_trim_q}), got, "range decode");
        end
        wr(OFF_CTRL_HIGH, 8'h00);
        settle();
        chk(34'(current_range_q), 34'h0, "range while disabled");
        $display("test current control done");
        wr(OFF_CTRL_HIGH, 8'h80);
        wr(OFF_FLAGS, 8'h00);
        irq_enable <= 1'b1;
        wr(OFF_CTRL_LOW, 8'h01);
        settle();
        chk(34'({current_on_q, irq_q}), 34'h2, "one status");
        wr(OFF_CTRL_LOW, 8'h03);
        settle();
        chk(34'({current_on_q, irq_q}), 34'h1, "both status");
        rd_chk(OFF_FLAGS, 8'h08, "flag set");
        wr(OFF_FLAGS, 8'h00);
        wr(OFF_CTRL_LOW, 8'h00);
        settle();
        chk(34'(irq_q), 34'h0, "flag cleared");
        irq_enable <= 1'b0;
        wr(OFF_CTRL_LOW, 8'h02);
        wr(OFF_CTRL_LOW, 8'h00);
        settle();
        rd_chk(OFF_FLAGS, 8'h08, "masked flag");
        chk(34'(irq_q), 34'h0, "masked irq");
        wr(OFF_FLAGS, 8'h00);
        wr(OFF_CTRL_LOW, 8'h9c);
        wr(OFF_CTRL_HIGH, 8'h88);
        settle();
        rd_chk(OFF_CTRL_LOW, 8'h9c, "inactive config");
        wr(OFF_CTRL_LOW, 8'h8c);
        settle();
        rd_chk(OFF_CTRL_LOW, 8'h8d, "reconfig");
        $display("test status and flag done");
        wr(OFF_CTRL_HIGH, 8'h80);
        wr(OFF_CTRL_LOW, 8'hdc);
        wr(OFF_FLAGS, 8'h00);
        irq_enable <= 1'b1;
        wr(OFF_CTRL_HIGH, 8'h8d);
        level_cmd <= 4'h2;
        settle();
        rd_chk(OFF_CTRL_LOW, 8'hdc, "two before one");
        level_cmd <= 4'h3;
        settle();
        rd_chk(OFF_CTRL_LOW, 8'hdf, "sequence done");
        rd_chk(OFF_FLAGS, 8'h08, "sequence flag");
        chk(34'({current_on_q, irq_q}), 34'h1, "sequence gate");
        chk(34'(conv_count), 34'h1, "conversions");
        $display("test sequence done");
        print_verdict();
    end
endmodule // charge_time_unit_test

// [sim/edge_source_model.sv]
// model of the edge sources and the converter that face the charge time unit
`timescale 1ns/100ps
module edge_source_model (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] level_cmd,
    input  wire logic       converter_start_q,
    output logic            edge_pin_one,
    output logic            edge_pin_two,
    output logic            capture_one_trig,
    output logic            capture_two_trig,
    output int              conv_count
);
    // levels change just after an edge, as real pins would
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {capture_two_trig, capture_one_trig, edge_pin_two, edge_pin_one} <= 4'h0;
            conv_count <= 0;
        end else begin
            {capture_two_trig, capture_one_trig, edge_pin_two, edge_pin_one} <= level_cmd;
            if (converter_start_q) begin
                conv_count <= conv_count + 1;
            end
        end
    end
endmodule // edge_source_model
